/* File: sai_pkg.sv */
// Shared constants, types and helpers of the serial audio receiver
// and clock monitor.
// Assumes a single 125 MHz system clock drives every user of it.
package sai_pkg;

  // System clock
  localparam int CLK_HZ  = 125_000_000;
  localparam int CLK_MHZ = 125;

  // Register offsets on the local register port
  localparam logic [7:0] ADDR_FMT_CFG  = 8'h04;
  localparam logic [7:0] ADDR_STATUS   = 8'h05;
  localparam logic [7:0] ADDR_RATE     = 8'h06;
  localparam logic [7:0] ADDR_VOL_RAMP = 8'h0e;

  // Reset values: I2S framing, 24-bit words, hard unmute
  localparam logic [7:0] FMT_CFG_RST  = 8'h08;
  localparam logic [7:0] VOL_RAMP_RST = 8'h00;

  // Field positions
  localparam int FMT_LSB         = 0;
  localparam int WLEN_LSB        = 2;
  localparam int SOFT_UNMUTE_BIT = 0;
  localparam int ST_LOCKED_BIT   = 0;
  localparam int ST_MUTED_BIT    = 1;
  localparam int ST_LIMP_BIT     = 2;
  localparam int ST_RATIO_LSB    = 3;
  localparam int ST_MCLK_OK_BIT  = 5;

  // Sample word
  localparam int SAMPLE_W = 24;

  // Bit clocks per frame that are accepted
  localparam logic [6:0] RATIO_32 = 7'h20;
  localparam logic [6:0] RATIO_48 = 7'h30;
  localparam logic [6:0] RATIO_64 = 7'h40;

  // Word length codes and their widths
  localparam logic [1:0] WLEN_16_CODE = 2'h0;
  localparam logic [1:0] WLEN_20_CODE = 2'h1;
  localparam logic [4:0] WLEN_16 = 5'h10;
  localparam logic [4:0] WLEN_20 = 5'h14;
  localparam logic [4:0] WLEN_24 = 5'h18;

  // Timing: frame timeout, master clock window, ramp step
  localparam int FRAME_TMO_US  = 200;
  localparam int FRAME_TMO_CYC = FRAME_TMO_US * CLK_MHZ;
  localparam int MCLK_WIN_NS   = 8192;
  localparam int MCLK_WIN_CYC  = (MCLK_WIN_NS * CLK_MHZ + 999) / 1000;
  localparam int RAMP_STEP_US  = 20;
  localparam int RAMP_CYC      = RAMP_STEP_US * CLK_MHZ;
  localparam int STABLE_FRAMES = 4;
  localparam int MCLK_MIN_EDGES = 16;
  localparam int MCLK_MAX_EDGES = 220;

  // Supported sample rates in Hz, index is the rate code
  localparam int RATE_N = 9;
  localparam int RATE_HZ [RATE_N] = '{8000, 11025, 12000, 16000, 22050,
                                      24000, 32000, 44100, 48000};

  typedef enum logic [1:0] {
    I2S_FMT,
    LEFT_JUSTIFIED_FMT,
    RIGHT_JUSTIFIED_FMT
  } sai_fmt_t;

  typedef enum logic [1:0] {
    ST_MUTE,
    ST_LIMP,
    ST_WAIT,
    ST_RUN
  } sai_state_t;

  // Ratio code: 1/2/3 for 32/48/64 bit clocks, 0 for anything else
  function automatic logic [1:0] sai_ratio_code(input logic [6:0] bits);
    logic [1:0] c;
    c = 2'h0;
    if (bits == RATIO_32) c = 2'h1;
    if (bits == RATIO_48) c = 2'h2;
    if (bits == RATIO_64) c = 2'h3;
    return c;
  endfunction

  // Nearest supported rate to a frame period in system clocks
  function automatic logic [3:0] sai_rate_code(input logic [15:0] period);
    int best;
    int diff;
    int d;
    best = 0;
    diff = 32'h7fffffff;
    for (int i = 0; i < RATE_N; i++) begin
      d = int'(period) - CLK_HZ / RATE_HZ[i];
      if (d < 0) d = -d;
      if (d < diff) begin
        diff = d;
        best = i;
      end
    end
    return best[3:0];
  endfunction

  // Configured word length in bits
  function automatic logic [4:0] sai_wlen(input logic [1:0] code);
    return (code == WLEN_16_CODE) ? WLEN_16 :
           (code == WLEN_20_CODE) ? WLEN_20 : WLEN_24;
  endfunction

endpackage

/* File: sai_sync_edge.sv */
// Two-flop synchroniser with rising edge detect for one async input.
// Assumes the input toggles slower than half the system clock.
`timescale 1ns/100ps
module sai_sync_edge (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic async_i,
  output logic      level_o,
  output logic      rise_o
);

  logic meta_q;
  logic sync_q;
  logic last_q;

  // First flop feeds only the second one
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // Edge taken between second and third flop
  assign level_o = sync_q;
  assign rise_o  = sync_q & ~last_q;

endmodule // sai_sync_edge

/* File: sai_rx.sv */
// Serial audio receiver with clock ratio check, rate detect and mute.
// Assumes serial clocks arrive asynchronously and are slow against clk_i.
// Function
// - bit clock must be 32, 48 or 64 per frame; checked every frame.
// - core clock taken from master clock, or oscillator when it fails.
// - detected rate and ratio drive the clock control setting.
// - on clock error mute in one step, then enter limp mode.
// - once stable, relock and restore volume in one step by default.
// - volume ramp register bit selects gradual soft unmute.
// - accept 16, 20 or 24 bit words in I2S, left or right justified.
// - I2S word select low is left, high is right.
// - I2S most significant bit comes one bit clock after the change.
// - bits arrive MSB first and are taken on bit clock rising edge.
// - I2S and left justified drop trailing bits past word length.
// - left justified: high is left; MSB at the word select change.
// - right justified: LSB sits in last bit clock before the change.
// - right justified drops leading bits before the word length.
// - samples are signed two's complement.
`timescale 1ns/100ps
module sai_rx
  import sai_pkg::*;
#(
  parameter int FRAME_TMO = FRAME_TMO_CYC
) (
  input  wire logic                clk_i,
  input  wire logic                rst_b_i,
  input  wire logic                mclk_i,
  input  wire logic                bit_clk_i,
  input  wire logic                word_sel_i,
  input  wire logic                serial_audio_in_i,
  input  wire logic [7:0]          reg_addr_i,
  input  wire logic                reg_wr_i,
  input  wire logic [7:0]          reg_wdata_i,
  output logic      [7:0]          reg_rdata_o,
  output logic [SAMPLE_W-1:0]      left_sample_o,
  output logic [SAMPLE_W-1:0]      right_sample_o,
  output logic                     frame_valid_o,
  output logic                     mute_o,
  output logic      [7:0]          gain_o,
  output logic                     core_clk_from_osc_o,
  output logic                     pll_limp_o,
  output logic                     locked_o,
  output logic      [3:0]          clk_cfg_rate_o,
  output logic      [1:0]          clk_cfg_ratio_o
);

  logic bclk_rise, ws_lvl, sd_lvl, mclk_rise;

  // Every serial pin passes the same sync depth, keeping them aligned
  sai_sync_edge u_bclk (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .async_i(bit_clk_i), .level_o(), .rise_o(bclk_rise));
  sai_sync_edge u_ws (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .async_i(word_sel_i), .level_o(ws_lvl), .rise_o());
  sai_sync_edge u_sd (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .async_i(serial_audio_in_i), .level_o(sd_lvl), .rise_o());
  sai_sync_edge u_mclk (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .async_i(mclk_i), .level_o(), .rise_o(mclk_rise));

  logic [7:0]          fmt_cfg_q, vol_ramp_q;
  logic                ws_prev_q, eff_prev_q, seen_q, have_left_q;
  logic [SAMPLE_W-1:0] sh_q, left_hold_q;
  logic [4:0]          cnt_q;
  logic [6:0]          fbits_q;
  logic [15:0]         period_q;
  logic [10:0]         win_q;
  logic [7:0]          medges_q;
  logic                mclk_ok_q;
  sai_state_t          state_q, state_d;
  logic [2:0]          stable_q;
  logic [1:0]          lock_ratio_q;
  logic [3:0]          lock_rate_q;
  logic [11:0]         ramp_q;

  // Format decode
  wire sai_fmt_t fmt      = sai_fmt_t'(fmt_cfg_q[FMT_LSB +: 2]);
  wire logic     is_i2s   = (fmt == I2S_FMT);
  wire logic     is_rj    = (fmt == RIGHT_JUSTIFIED_FMT);
  wire logic [4:0] wlen   = sai_wlen(fmt_cfg_q[WLEN_LSB +: 2]);
  wire logic     soft_en  = vol_ramp_q[SOFT_UNMUTE_BIT];

  // I2S slot boundary delayed one bit clock
  wire logic eff_ws   = is_i2s ? ws_prev_q : ws_lvl;
  wire logic boundary = bclk_rise & (eff_ws != eff_prev_q);
  wire logic new_left = is_i2s ? ~eff_ws : eff_ws;
  wire logic f_start  = boundary & new_left;
  wire logic f_done   = f_start & seen_q;

  // shift stops once word length reached
  // right justified keeps only the last bits shifted in
  wire logic take_bit = is_rj | (cnt_q < wlen);
  // MSB aligned to bit 23 keeps the two's complement sign
  wire logic [SAMPLE_W-1:0] aligned =
    sh_q << (5'(SAMPLE_W) - wlen);

  // ratio check on the bit clocks of the finished frame
  wire logic [1:0] f_ratio = sai_ratio_code(fbits_q);
  // frame period mapped to a rate code
  wire logic [3:0] f_rate  = sai_rate_code(period_q);
  wire logic f_good    = (f_ratio != 2'h0);
  wire logic f_match   = (f_ratio == lock_ratio_q) & (f_rate == lock_rate_q);
  wire logic timeout   = (period_q >= 16'(FRAME_TMO));
  wire logic clk_err   = timeout | ~mclk_ok_q | (f_done & ~(f_good & f_match));
  wire logic ramp_tick = (ramp_q == 12'(RAMP_CYC - 1));
  wire logic win_end   = (win_q == 11'(MCLK_WIN_CYC - 1));

  // Register writes
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fmt_cfg_q  <= FMT_CFG_RST;
      vol_ramp_q <= VOL_RAMP_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == ADDR_FMT_CFG) fmt_cfg_q <= reg_wdata_i;
      if (reg_addr_i == ADDR_VOL_RAMP) vol_ramp_q <= reg_wdata_i;
    end
  end

  // Register reads, unmapped offsets read zero
  wire logic [7:0] status = {2'h0, mclk_ok_q, lock_ratio_q, pll_limp_o,
                             mute_o, locked_o};
  wire logic [7:0] rdata  =
    (reg_addr_i == ADDR_FMT_CFG)  ? fmt_cfg_q :
    (reg_addr_i == ADDR_STATUS)   ? status :
    (reg_addr_i == ADDR_RATE)     ? {4'h0, lock_rate_q} :
    (reg_addr_i == ADDR_VOL_RAMP) ? vol_ramp_q : 8'h00;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) reg_rdata_o <= 8'h00;
    else          reg_rdata_o <= rdata;
  end

  // bits taken on each bit clock rising edge, MSB first
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ws_prev_q  <= 1'b0;
      eff_prev_q <= 1'b0;
      sh_q       <= '0;
      cnt_q      <= 5'h00;
    end else if (bclk_rise) begin
      ws_prev_q  <= ws_lvl;
      eff_prev_q <= eff_ws;
      if (boundary) begin
        sh_q  <= {{(SAMPLE_W-1){1'b0}}, sd_lvl};
        cnt_q <= 5'h01;
      end else if (take_bit) begin
        sh_q  <= {sh_q[SAMPLE_W-2:0], sd_lvl};
        cnt_q <= (cnt_q == 5'h1f) ? cnt_q : cnt_q + 5'h01;
      end
    end
  end

  // slot close collects left then right
  // right justified LSB is the bit just before the boundary
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      left_hold_q <= '0;
      have_left_q <= 1'b0;
    end else if (boundary) begin
      left_hold_q <= new_left ? left_hold_q : aligned;
      have_left_q <= ~new_left & seen_q;
    end
  end

  // one-cycle valid; zeroed by the mute level being entered
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      left_sample_o  <= '0;
      right_sample_o <= '0;
      frame_valid_o  <= 1'b0;
    end else begin
      frame_valid_o <= f_start & have_left_q;
      if (f_start & have_left_q) begin
        left_sample_o  <= (state_d != ST_RUN) ? '0 : left_hold_q;
        right_sample_o <= (state_d != ST_RUN) ? '0 : aligned;
      end
    end
  end

  // Bit clocks and system clocks per frame; first frame is partial
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fbits_q  <= 7'h00;
      period_q <= 16'h0000;
      seen_q   <= 1'b0;
    end else begin
      if (f_start) begin
        fbits_q  <= 7'h01;
        period_q <= 16'h0000;
        seen_q   <= 1'b1;
      end else begin
        if (bclk_rise && fbits_q != 7'h7f) fbits_q <= fbits_q + 7'h01;
        if (period_q != 16'hffff) period_q <= period_q + 16'h0001;
        if (timeout) seen_q <= 1'b0;
      end
    end
  end

  // master clock edge count over a fixed window
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      win_q     <= 11'h000;
      medges_q  <= 8'h00;
      mclk_ok_q <= 1'b0;
    end else if (win_end) begin
      win_q     <= 11'h000;
      medges_q  <= 8'h00;
      mclk_ok_q <= (medges_q >= 8'(MCLK_MIN_EDGES)) &
                   (medges_q <= 8'(MCLK_MAX_EDGES));
    end else begin
      win_q <= win_q + 11'h001;
      if (mclk_rise && medges_q != 8'hff) medges_q <= medges_q + 8'h01;
    end
  end

  // Lock state machine; limp holds until frames agree for a while
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_MUTE: state_d = ST_LIMP;
      ST_LIMP: if (mclk_ok_q && f_done && f_good) state_d = ST_WAIT;
      ST_WAIT: begin
        if (clk_err) state_d = ST_LIMP;
        else if (f_done && stable_q == 3'(STABLE_FRAMES - 1))
          state_d = ST_RUN;
      end
      // any clock change or error leaves normal operation
      ST_RUN:  if (clk_err) state_d = ST_MUTE;
      default: state_d = ST_LIMP;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q      <= ST_LIMP;
      stable_q     <= 3'h0;
      lock_ratio_q <= 2'h0;
      lock_rate_q  <= 4'h0;
    end else begin
      state_q <= state_d;
      if (state_q == ST_LIMP && state_d == ST_WAIT) begin
        lock_ratio_q <= f_ratio;
        lock_rate_q  <= f_rate;
        stable_q     <= 3'h1;
      end else if (state_q == ST_WAIT && f_done) begin
        stable_q <= stable_q + 3'h1;
      end
    end
  end

  // Ramp step divider, free running; a step may come early once
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i)       ramp_q <= 12'h000;
    else if (ramp_tick) ramp_q <= 12'h000;
    else                ramp_q <= ramp_q + 12'h001;
  end

  // one-step mute, then limp on the oscillator
  // hard unmute on relock unless soft unmute is set
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mute_o     <= 1'b1;
      gain_o     <= 8'h00;
      pll_limp_o <= 1'b1;
      locked_o   <= 1'b0;
    end else begin
      if (state_d == ST_MUTE || state_d == ST_LIMP) begin
        mute_o     <= 1'b1;
        gain_o     <= 8'h00;
        pll_limp_o <= 1'b1;
        locked_o   <= 1'b0;
      end else if (state_q == ST_WAIT && state_d == ST_RUN) begin
        mute_o     <= 1'b0;
        gain_o     <= soft_en ? 8'h00 : 8'hff;
        pll_limp_o <= 1'b0;
        locked_o   <= 1'b1;
      end else if (state_q == ST_RUN && ramp_tick && gain_o != 8'hff) begin
        // gradual ramp back to full volume
        gain_o <= gain_o + 8'h01;
      end
    end
  end

  // oscillator chosen whenever limp or master clock bad
  // clock control setting follows the locked codes
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      core_clk_from_osc_o <= 1'b1;
      clk_cfg_rate_o      <= 4'h0;
      clk_cfg_ratio_o     <= 2'h0;
    end else begin
      core_clk_from_osc_o <= pll_limp_o | ~mclk_ok_q;
      clk_cfg_rate_o      <= lock_rate_q;
      clk_cfg_ratio_o     <= lock_ratio_q;
    end
  end

endmodule // sai_rx

/* File: sai_rx_properties.sv */
// Port-level assertions for the serial audio receiver.
// Assumes binding to sai_rx and a view of its ports only.
`timescale 1ns/100ps
module sai_rx_properties
  import sai_pkg::*;
#(
  parameter int FRAME_TMO = FRAME_TMO_CYC
) (
  input wire logic                clk_i,
  input wire logic                rst_b_i,
  input wire logic [7:0]          reg_addr_i,
  input wire logic                reg_wr_i,
  input wire logic [7:0]          reg_wdata_i,
  input wire logic [7:0]          reg_rdata_o,
  input wire logic [SAMPLE_W-1:0] left_sample_o,
  input wire logic [SAMPLE_W-1:0] right_sample_o,
  input wire logic                frame_valid_o,
  input wire logic                mute_o,
  input wire logic [7:0]          gain_o,
  input wire logic                core_clk_from_osc_o,
  input wire logic                pll_limp_o,
  input wire logic                locked_o,
  input wire logic [3:0]          clk_cfg_rate_o,
  input wire logic [1:0]          clk_cfg_ratio_o
);
  // One domain, quiet while reset is held
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  // Steps of error entry, relock and a ramp register write
  sequence s_err; $rose(mute_o); endsequence
  sequence s_lock; $rose(locked_o); endsequence
  sequence s_vol_wr; reg_wr_i && reg_addr_i == ADDR_VOL_RAMP; endsequence

  property p_mute_limp; s_err |-> pll_limp_o && !locked_o; endproperty
  a_mute_limp: assert property (p_mute_limp)
    else $error("limp not entered with mute");
  property p_osc; s_err |-> ##1 core_clk_from_osc_o; endproperty
  a_osc: assert property (p_osc)
    else $error("oscillator not selected after error");
  property p_muted_gain; mute_o |-> gain_o == 8'h00; endproperty
  a_muted_gain: assert property (p_muted_gain)
    else $error("gain not zero while muted");
  property p_unmute;
    s_lock |-> !mute_o && !pll_limp_o && (gain_o == 8'hff || gain_o == 8'h00);
  endproperty
  a_unmute: assert property (p_unmute)
    else $error("bad state at relock");
  property p_soft_step;
    !mute_o && $changed(gain_o) && gain_o != 8'hff
      |-> gain_o == $past(gain_o) + 8'h01;
  endproperty
  a_soft_step: assert property (p_soft_step)
    else $error("gain ramp step not one");
  property p_vol_rd;
    s_vol_wr ##1 (reg_addr_i == ADDR_VOL_RAMP && !reg_wr_i)
      |=> reg_rdata_o == $past(reg_wdata_i, 2);
  endproperty
  a_vol_rd: assert property (p_vol_rd)
    else $error("ramp register readback wrong");
  property p_valid_pulse; frame_valid_o |=> !frame_valid_o [*8]; endproperty
  a_valid_pulse: assert property (p_valid_pulse)
    else $error("frame strobe too long");
  property p_zero_muted;
    frame_valid_o && mute_o |-> left_sample_o == '0 && right_sample_o == '0;
  endproperty
  a_zero_muted: assert property (p_zero_muted)
    else $error("samples not silent while muted");
  property p_ratio; locked_o |-> clk_cfg_ratio_o != 2'h0; endproperty
  a_ratio: assert property (p_ratio)
    else $error("locked with no ratio");
  property p_rate; locked_o |-> clk_cfg_rate_o <= 4'h8; endproperty
  a_rate: assert property (p_rate)
    else $error("rate code out of range");
endmodule // sai_rx_properties

bind sai_rx sai_rx_properties #(.FRAME_TMO(FRAME_TMO)) i_props (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .left_sample_o(left_sample_o), .right_sample_o(right_sample_o),
  .frame_valid_o(frame_valid_o), .mute_o(mute_o), .gain_o(gain_o),
  .core_clk_from_osc_o(core_clk_from_osc_o), .pll_limp_o(pll_limp_o),
  .locked_o(locked_o), .clk_cfg_rate_o(clk_cfg_rate_o),
  .clk_cfg_ratio_o(clk_cfg_ratio_o));

/* File: sai_src_model.sv */
// Behavioural audio source: master clock, bit clock, word select, data.
// Assumes clk_i at 125 MHz; one bit clock is 20 of its cycles (160 ns).
`timescale 1ns/100ps
module sai_src_model
  import sai_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        run_i,
  input  wire logic        mclk_en_i,
  input  wire sai_fmt_t    fmt_i,
  input  wire logic [5:0]  slot_i,
  input  wire logic [4:0]  wlen_i,
  input  wire logic [23:0] left_i,
  input  wire logic [23:0] right_i,
  output logic             mclk_o,
  output logic             bclk_o,
  output logic             ws_o,
  output logic             sd_o,
  output logic             start_o
);
  logic [2:0]  mdiv = 3'h0;
  logic [1:0]  fm;
  logic [5:0]  sl;
  logic [4:0]  wn;
  logic [23:0] wl, wr, w;
  logic        ch;
  int          i, pos;

  // Master clock at an eighth of clk_i, parked low when switched off
  always @(posedge clk_i) begin
    mdiv <= mdiv + 3'h1;
    mclk_o <= mclk_en_i & mdiv[2];
  end

  // One frame a pass; settings latched so mid-frame changes wait
  initial begin
    {bclk_o, ws_o, sd_o, start_o} = 4'h4;
    forever begin
      @(posedge clk_i);
      if (!run_i)
        sd_o <= ~sd_o;
      else begin
        {fm, sl, wn, wl, wr} = {fmt_i, slot_i, wlen_i, left_i, right_i};
        for (int s = 0; s < 2 * sl; s++) begin
          ch = (s >= sl);
          i = ch ? s - sl : s;
          pos = (fm == I2S_FMT) ? i - 1 :
                (fm == RIGHT_JUSTIFIED_FMT) ? i - (sl - wn) : i;
          w = ch ? wr : wl;
          ws_o <= (fm == I2S_FMT) ? ch : !ch;
          sd_o <= (pos >= 0 && pos < wn) ? w[23 - pos] : ~sd_o;
          bclk_o <= 1'b0;
          start_o <= (s == 0);
          @(posedge clk_i);
          start_o <= 1'b0;
          repeat (9) @(posedge clk_i);
          bclk_o <= 1'b1;
          repeat (10) @(posedge clk_i);
        end
      end
    end
  end
endmodule // sai_src_model

/* File: sai_rx_tb.sv */
// Self-checking bench for the serial audio receiver and clock monitor.
// Assumes sai_src_model as the far side and the bound property checker.
`timescale 1ns/100ps
module sai_rx_tb
  import sai_pkg::*;
();
  logic        clk = 1'b0, rst_b = 1'b0, mclk_en = 1'b1, run = 1'b0;
  logic        chk_on = 1'b0, unm_q = 1'b0, reg_wr = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, rdata, gain;
  logic [5:0]  sl = 6'h20;
  logic [4:0]  wn = 5'h18;
  sai_fmt_t    fm = I2S_FMT;
  logic [23:0] lft = 24'h0, rgt = 24'h0, ls, rs;
  logic        mclk, bclk, ws, sd, start, valid, mute, osc, limp, locked;
  logic [3:0]  rate;
  logic [1:0]  ratio;
  logic [47:0] nq [$];
  logic [47:0] e;
  int          checked = 0, fail_count = 0;
  wire  [23:0] msk = 24'hffffff << (5'h18 - wn);
  wire  [4:0]  watch = {valid, start, gain == 8'h01, locked, mute};
  logic [7:0]  cfg [4] = '{8'h08, 8'h05, 8'h02, 8'h0a};
  logic [5:0]  slot [4] = '{6'h20, 6'h18, 6'h10, 6'h20};

  sai_rx #(.FRAME_TMO(3000)) i_dut (
    .clk_i(clk), .rst_b_i(rst_b), .mclk_i(mclk), .bit_clk_i(bclk),
    .word_sel_i(ws), .serial_audio_in_i(sd), .reg_addr_i(reg_addr),
    .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata), .reg_rdata_o(rdata),
    .left_sample_o(ls), .right_sample_o(rs), .frame_valid_o(valid),
    .mute_o(mute), .gain_o(gain), .core_clk_from_osc_o(osc),
    .pll_limp_o(limp), .locked_o(locked), .clk_cfg_rate_o(rate),
    .clk_cfg_ratio_o(ratio));
  sai_src_model i_src (
    .clk_i(clk), .run_i(run), .mclk_en_i(mclk_en), .fmt_i(fm), .slot_i(sl),
    .wlen_i(wn), .left_i(lft), .right_i(rgt), .mclk_o(mclk), .bclk_o(bclk),
    .ws_o(ws), .sd_o(sd), .start_o(start));

  // 125 MHz system clock
  initial begin
    forever #4 clk = ~clk;
  end

  task automatic check(input string what, input logic [47:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Bounded wait on one watched flag; a timeout ends the run
  task automatic wt(input int b, input int lim);
    for (int n = 0; n < lim; n++) begin
      @(posedge clk);
      if (watch[b] === 1'b1) return;
    end
    fail_count++;
    $display("CHECK FAILED wait %0d exp 1 seen timeout", b);
    wrap_up();
  endtask

  task automatic reg_put(input logic [7:0] a, d);
    @(posedge clk);
    reg_addr <= a;
    reg_wr <= 1'b1;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_get(input logic [7:0] a, exp);
    @(posedge clk);
    reg_addr <= a;
    repeat (2) @(posedge clk);
    check("register read", rdata, exp);
  endtask

  // Note each frame as the source starts it, then pick fresh words
  always @(posedge clk) begin
    if (start === 1'b1) begin
      nq.push_back({lft, rgt});
      lft <= 24'($urandom) & msk;
      rgt <= 24'($urandom) & msk;
    end
  end

  // Stale notes dropped: the closed frame is the older of the last two
  always @(posedge clk) begin
    unm_q <= (mute === 1'b0);
    if (valid === 1'b1) begin
      while (nq.size() > 2) nq.delete(0);
      e = (nq.size() > 0) ? nq.pop_front() : 48'h0;
      if (mute !== 1'b0)
        check("muted samples", {ls, rs}, 48'h0);
      else if (chk_on && unm_q)
        check("samples", {ls, rs}, e);
    end
  end

  // Reset, registers, four framings, then master clock loss
  initial begin
    void'($urandom(60382));
    repeat (6) @(posedge clk);
    check("reset outputs", {mute, limp, osc, locked, valid}, 48'h1c);
    rst_b <= 1'b1;
    reg_get(ADDR_FMT_CFG, FMT_CFG_RST);
    reg_get(ADDR_VOL_RAMP, VOL_RAMP_RST);
    reg_get(8'h01, 8'h00);
    run <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      chk_on <= 1'b0;
      wt(3, 3000);
      fm <= sai_fmt_t'(cfg[k][1:0]);
      sl <= slot[k];
      wn <= 5'h10 + {cfg[k][3:2], 2'h0};
      if (k > 0) wt(0, 6000);
      reg_put(ADDR_FMT_CFG, cfg[k]);
      if (k == 3) begin
        reg_put(ADDR_VOL_RAMP, 8'h01);
        reg_get(ADDR_VOL_RAMP, 8'h01);
      end
      wt(1, 20000);
      check("unmute gain", gain, (k == 3) ? 8'h00 : 8'hff);
      // Source select trails the limp flag by one cycle
      @(posedge clk);
      check("clock setting", {rate, ratio, limp, osc},
            {4'h8, 2'(slot[k] / 8 - 1), 2'h0});
      reg_get(ADDR_STATUS, {3'h1, 2'(slot[k] / 8 - 1), 3'h1});
      reg_get(ADDR_RATE, 8'h08);
      if (k == 3) wt(2, 3000);
      chk_on <= 1'b1;
      repeat (4) wt(4, 2000);
    end
    mclk_en <= 1'b0;
    chk_on <= 1'b0;
    wt(0, 4000);
    @(posedge clk);
    check("oscillator fallback", {limp, osc}, 48'h3);
    mclk_en <= 1'b1;
    wt(1, 20000);
    @(posedge clk);
    check("master clock back", {limp, osc}, 48'h0);
    wrap_up();
  end
endmodule // sai_rx_tb
